// ===== hw/spmri_pkg.sv
// shared constants and helpers for the switch port mii/rmii link
package spmri_pkg;
    localparam int NPORT = 2;
    localparam int P3 = 0;
    localparam int P4 = 1;
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int LINK_PERIOD_NS = 200;
    localparam int LINK_HALF = (LINK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    localparam logic [2:0] LINK_HALF_M1 = 3'(LINK_HALF - 1);
    localparam int RMII_HOLD_10M = 10;
    localparam logic [3:0] HOLD_M1 = 4'(RMII_HOLD_10M - 1);
    localparam logic [1:0] STRAP_WAIT = 2'h2;
    // register map
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_STAT = 2'h1;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam int CTRL_P3_SPD10 = 0;
    localparam int CTRL_P4_SPD10 = 1;
    localparam int CTRL_P3_REFOFF = 2;
    localparam int CTRL_P4_REFOFF = 3;
    localparam int CTRL_P3_MAC = 6;
    localparam int ST_P3_RMII = 0;
    localparam int ST_P4_RMII = 1;
    localparam int ST_NORMAL = 2;
    localparam int ST_P3_MAC = 3;
    localparam int ST_P4_MAC = 4;
    localparam int ST_COL0 = 5;
    localparam int ST_STRAP_OK = 7;

    // rmii dibit of a nibble, low pair first
    function automatic logic [1:0] spmri_dibit(input logic [3:0] n, input logic hi);
        spmri_dibit = hi ? n[3:2] : n[1:0];
    endfunction
endpackage

// ===== hw/spmri_link_if.sv
// pin-level link between switch ports 3/4 and their partners
interface spmri_link_if;
    // device side drives
    logic [1:0] d_rxc;
    logic [1:0] d_rxc_oe_n;
    logic [1:0] d_txc;
    logic [1:0] d_txc_oe_n;
    logic [1:0][3:0] d_rxd;
    logic [1:0] d_rxdv;
    logic [1:0] d_crs;
    logic [1:0] d_col;
    logic [1:0] d_cc_oe_n;
    // partner side drives
    logic [1:0][3:0] p_txd;
    logic [1:0] p_txen;
    logic [1:0] p_rxc;
    logic [1:0] p_rxc_oe_n;
    logic [1:0] p_txc;
    logic [1:0] p_txc_oe_n;
    logic [1:0] p_crs;
    logic [1:0] p_col;
    logic [1:0] p_cc_oe_n;
    // outside reference or loopback source
    logic [1:0] ext_ref;
    // resolved wires
    logic [1:0] w_rxc;
    logic [1:0] w_txc;
    logic [1:0] w_crs;
    logic [1:0] w_col;

    assign w_rxc = (~d_rxc_oe_n & d_rxc) | (d_rxc_oe_n & ~p_rxc_oe_n & p_rxc)
                 | (d_rxc_oe_n & p_rxc_oe_n & ext_ref);
    assign w_txc = (~d_txc_oe_n & d_txc) | (d_txc_oe_n & ~p_txc_oe_n & p_txc)
                 | (d_txc_oe_n & p_txc_oe_n & ext_ref);
    assign w_crs = (~d_cc_oe_n & d_crs) | (d_cc_oe_n & ~p_cc_oe_n & p_crs);
    assign w_col = (~d_cc_oe_n & d_col) | (d_cc_oe_n & ~p_cc_oe_n & p_col);

    modport dev (
        output d_rxc, d_rxc_oe_n, d_txc, d_txc_oe_n, d_rxd, d_rxdv, d_crs, d_col, d_cc_oe_n,
        input p_txd, p_txen, w_rxc, w_txc, w_crs, w_col
    );
    modport par (
        output p_txd, p_txen, p_rxc, p_rxc_oe_n, p_txc, p_txc_oe_n, p_crs, p_col, p_cc_oe_n,
        input d_rxd, d_rxdv, w_rxc, w_txc, w_crs, w_col
    );
endinterface

// ===== hw/spmri_switch_port.sv
// switch ports 3 and 4: mii/rmii media-side data interface
module spmri_switch_port
    import spmri_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link pins
    spmri_link_if.dev lnk,
    // straps
    input wire logic port3_interface_type_strap,
    input wire logic port4_interface_type_strap,
    input wire logic clock_source_strap,
    input wire logic port4_role_cfg,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    // data toward partner
    input wire logic [1:0] tx_valid,
    input wire logic [1:0][3:0] tx_nib,
    output logic [1:0] tx_ready,
    // data from partner
    output logic [1:0] rx_valid,
    output logic [1:0][3:0] rx_nib
);
    // strap capture after reset release
    logic [3:0] strap_m_r;
    logic [3:0] strap_s_r;
    logic [1:0] cap_cnt_r;
    logic cap_r;
    logic [1:0] rmii_r;
    logic normal_r;
    logic p4mac_r;
    logic [7:0] ctrl_r;
    logic [1:0] col_seen_r;
    logic [1:0] col_ev;
    logic [7:0] rdata_r;
    logic [2:0] div_cnt_r;
    logic div_clk_r;
    wire div_rise = (div_cnt_r == LINK_HALF_M1) & ~div_clk_r;
    wire [1:0] mac_w = {p4mac_r, ctrl_r[CTRL_P3_MAC]};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_m_r <= 4'h0;
            strap_s_r <= 4'h0;
        end else begin
            strap_m_r <= {port4_role_cfg, clock_source_strap, port4_interface_type_strap,
                          port3_interface_type_strap};
            strap_s_r <= strap_m_r;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cap_cnt_r <= 2'h0;
            cap_r <= 1'b0;
            rmii_r <= 2'h0;
            normal_r <= 1'b0;
            p4mac_r <= 1'b0;
        end else if (!cap_r) begin
            cap_cnt_r <= cap_cnt_r + 2'h1;
            if (cap_cnt_r == STRAP_WAIT) begin
                cap_r <= 1'b1;
                rmii_r[P3] <= ~strap_s_r[0];
                rmii_r[P4] <= ~strap_s_r[1];
                normal_r <= ~strap_s_r[2];
                p4mac_r <= strap_s_r[3];
            end
        end
    end

    // free-running link clock divider, stands in for the crystal-derived reference
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_r <= 3'h0;
            div_clk_r <= 1'b0;
        end else begin
            div_cnt_r <= (div_cnt_r == LINK_HALF_M1) ? 3'h0 : div_cnt_r + 3'h1;
            if (div_cnt_r == LINK_HALF_M1) begin
                div_clk_r <= ~div_clk_r;
            end
        end
    end

    // register file
    wire wr_ctrl = reg_we & (reg_addr == REG_CTRL);
    wire wr_stat = reg_we & (reg_addr == REG_STAT);
    wire [7:0] stat_w = {cap_r, col_seen_r, p4mac_r, ctrl_r[CTRL_P3_MAC], normal_r, rmii_r};
    wire [7:0] rd_mux = (reg_addr == REG_CTRL) ? ctrl_r : (reg_addr == REG_STAT) ? stat_w : 8'h00;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= CTRL_RST;
            rdata_r <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= reg_wdata;
            end
            rdata_r <= reg_re ? rd_mux : 8'h00;
        end
    end

    // collision seen: write one clears, a new event wins
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            col_seen_r <= 2'h0;
        end else begin
            col_seen_r <= col_ev | (col_seen_r & ~(wr_stat ? reg_wdata[ST_COL0+1:ST_COL0] : 2'h0));
        end
    end

    assign reg_rdata = rdata_r;

    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : g_port
            localparam bit IS_P4 = (g == P4);
            logic [2:0] ck_r;
            logic [4:0] din_m_r;
            logic [4:0] din_s_r;
            logic [1:0] cin_r;
            logic [3:0] hold_r;
            logic [3:0] nib_r;
            logic ph_r;
            logic pv_r;
            logic [3:0] pd_r;
            logic rdy_r;
            logic [3:0] rhold_r;
            logic rph_r;
            logic [1:0] rlo_r;
            logic rv_r;
            logic [3:0] rn_r;
            logic crs_r;
            logic col_r;
            logic rxc_oe_n_r;
            logic txc_oe_n_r;
            logic cc_oe_n_r;
            logic rxc_r;

            wire mii_mac = ~rmii_r[g] & mac_w[g];
            wire mii_phy = ~rmii_r[g] & ~mac_w[g];
            // in rmii port 3 never takes an outside reference
            wire ext_src = mii_mac | (rmii_r[g] & IS_P4 & normal_r);
            wire tick = ext_src ? (ck_r[1] & ~ck_r[2]) : div_rise;
            wire slow = rmii_r[g] & ctrl_r[g];
            wire slot = tick & (~slow | (hold_r == HOLD_M1));
            wire more = rmii_r[g] & pv_r & ~ph_r;
            wire ren = din_s_r[4];
            wire [3:0] rd = din_s_r[3:0];
            wire ref_on = rmii_r[g] & ~ctrl_r[CTRL_P3_REFOFF+g] & ~(IS_P4 & normal_r);

            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    ck_r <= 3'h0;
                    din_m_r <= 5'h00;
                    din_s_r <= 5'h00;
                    cin_r <= 2'h0;
                end else begin
                    ck_r <= {ck_r[1:0], lnk.w_txc[g]};
                    // only enable and data come in, no error line
                    din_m_r <= {lnk.p_txen[g], lnk.p_txd[g]};
                    din_s_r <= din_m_r;
                    cin_r <= {cin_r[0], lnk.w_col[g]};
                end
            end

            // transmit toward partner on the receive data pins
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    hold_r <= 4'h0;
                    nib_r <= 4'h0;
                    ph_r <= 1'b0;
                    pv_r <= 1'b0;
                    pd_r <= 4'h0;
                    rdy_r <= 1'b0;
                end else begin
                    rdy_r <= 1'b0;
                    if (tick) begin
                        hold_r <= slot ? 4'h0 : hold_r + 4'h1;
                    end
                    if (slot) begin
                        if (more) begin
                            ph_r <= 1'b1;
                            pd_r <= {2'h0, spmri_dibit(nib_r, 1'b1)};
                        end else if (tx_valid[g]) begin
                            nib_r <= tx_nib[g];
                            pv_r <= 1'b1;
                            ph_r <= 1'b0;
                            rdy_r <= 1'b1;
                            pd_r <= rmii_r[g] ? {2'h0, spmri_dibit(tx_nib[g], 1'b0)} : tx_nib[g];
                        end else begin
                            pv_r <= 1'b0;
                            ph_r <= 1'b0;
                            pd_r <= 4'h0;
                        end
                    end
                end
            end

            // receive from partner on the transmit data pins
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    rhold_r <= 4'h0;
                    rph_r <= 1'b0;
                    rlo_r <= 2'h0;
                    rv_r <= 1'b0;
                    rn_r <= 4'h0;
                end else begin
                    rv_r <= 1'b0;
                    if (tick) begin
                        if (!ren) begin
                            rhold_r <= 4'h0;
                            rph_r <= 1'b0;
                        end else begin
                            rhold_r <= (slow & (rhold_r != HOLD_M1)) ? rhold_r + 4'h1 : 4'h0;
                            if (rhold_r == 4'h0) begin
                                if (!rmii_r[g]) begin
                                    rv_r <= 1'b1;
                                    rn_r <= rd;
                                end else if (!rph_r) begin
                                    rlo_r <= rd[1:0];
                                    rph_r <= 1'b1;
                                end else begin
                                    rv_r <= 1'b1;
                                    rn_r <= {rd[1:0], rlo_r};
                                    rph_r <= 1'b0;
                                end
                            end
                        end
                    end
                end
            end

            // pin enables, carrier and collision
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    crs_r <= 1'b0;
                    col_r <= 1'b0;
                    rxc_oe_n_r <= 1'b1;
                    txc_oe_n_r <= 1'b1;
                    cc_oe_n_r <= 1'b1;
                    rxc_r <= 1'b0;
                end else begin
                    crs_r <= pv_r | ren;
                    col_r <= pv_r & ren;
                    rxc_oe_n_r <= ~(mii_phy | ref_on);
                    txc_oe_n_r <= ~mii_phy;
                    cc_oe_n_r <= ~mii_phy;
                    rxc_r <= div_rise ? 1'b1 : (div_cnt_r == LINK_HALF_M1) ? 1'b0 : div_clk_r;
                end
            end

            assign col_ev[g] = mii_mac ? cin_r[1] : (col_r & ~rmii_r[g]);
            assign lnk.d_rxc[g] = rxc_r;
            assign lnk.d_txc[g] = rxc_r;
            assign lnk.d_rxc_oe_n[g] = rxc_oe_n_r;
            assign lnk.d_txc_oe_n[g] = txc_oe_n_r;
            assign lnk.d_rxd[g] = pd_r;
            assign lnk.d_rxdv[g] = pv_r;
            assign lnk.d_crs[g] = crs_r;
            assign lnk.d_col[g] = col_r;
            assign lnk.d_cc_oe_n[g] = cc_oe_n_r;
            assign tx_ready[g] = rdy_r;
            assign rx_valid[g] = rv_r;
            assign rx_nib[g] = rn_r;
        end
    endgenerate
endmodule

// ===== hw/spmri_link_partner.sv
// external mac or phy attached to switch ports 3 and 4
module spmri_link_partner
    import spmri_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link pins
    spmri_link_if.par lnk,
    // per-port mode
    input wire logic [1:0] p_rmii,
    input wire logic [1:0] p_speed10,
    input wire logic [1:0] p_is_phy,
    // data toward device
    input wire logic [1:0] tx_valid,
    input wire logic [1:0][3:0] tx_nib,
    output logic [1:0] tx_ready,
    // data from device
    output logic [1:0] rx_valid,
    output logic [1:0][3:0] rx_nib
);
    // error inputs that the switch never drives are held low
    wire partner_receive_error_input = 1'b0;
    wire partner_transmit_error_input = 1'b0;
    logic [2:0] div_cnt_r;
    logic div_clk_r;
    wire div_rise = (div_cnt_r == LINK_HALF_M1) & ~div_clk_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_r <= 3'h0;
            div_clk_r <= 1'b0;
        end else begin
            div_cnt_r <= (div_cnt_r == LINK_HALF_M1) ? 3'h0 : div_cnt_r + 3'h1;
            if (div_cnt_r == LINK_HALF_M1) begin
                div_clk_r <= ~div_clk_r;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : g_port
            logic [2:0] ck_r;
            logic [4:0] din_m_r;
            logic [4:0] din_s_r;
            logic [3:0] hold_r;
            logic [3:0] nib_r;
            logic ph_r;
            logic pv_r;
            logic [3:0] pd_r;
            logic rdy_r;
            logic [3:0] rhold_r;
            logic rph_r;
            logic [1:0] rlo_r;
            logic rv_r;
            logic [3:0] rn_r;
            logic crs_r;
            logic col_r;
            logic drv_r;

            wire mii_phy = ~p_rmii[g] & p_is_phy[g];
            wire tick = mii_phy ? div_rise : (ck_r[1] & ~ck_r[2]);
            wire slow = p_rmii[g] & p_speed10[g];
            wire slot = tick & (~slow | (hold_r == HOLD_M1));
            wire more = p_rmii[g] & pv_r & ~ph_r;
            wire ren = din_s_r[4] & ~partner_receive_error_input & ~partner_transmit_error_input;
            wire [3:0] rd = din_s_r[3:0];

            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    ck_r <= 3'h0;
                    din_m_r <= 5'h00;
                    din_s_r <= 5'h00;
                end else begin
                    ck_r <= {ck_r[1:0], p_rmii[g] ? lnk.w_rxc[g] : lnk.w_txc[g]};
                    din_m_r <= {lnk.d_rxdv[g], lnk.d_rxd[g]};
                    din_s_r <= din_m_r;
                end
            end

            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    hold_r <= 4'h0;
                    nib_r <= 4'h0;
                    ph_r <= 1'b0;
                    pv_r <= 1'b0;
                    pd_r <= 4'h0;
                    rdy_r <= 1'b0;
                end else begin
                    rdy_r <= 1'b0;
                    if (tick) begin
                        hold_r <= slot ? 4'h0 : hold_r + 4'h1;
                    end
                    if (slot) begin
                        if (more) begin
                            ph_r <= 1'b1;
                            pd_r <= {2'h0, spmri_dibit(nib_r, 1'b1)};
                        end else if (tx_valid[g]) begin
                            nib_r <= tx_nib[g];
                            pv_r <= 1'b1;
                            ph_r <= 1'b0;
                            rdy_r <= 1'b1;
                            pd_r <= p_rmii[g] ? {2'h0, spmri_dibit(tx_nib[g], 1'b0)} : tx_nib[g];
                        end else begin
                            pv_r <= 1'b0;
                            ph_r <= 1'b0;
                            pd_r <= 4'h0;
                        end
                    end
                end
            end

            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    rhold_r <= 4'h0;
                    rph_r <= 1'b0;
                    rlo_r <= 2'h0;
                    rv_r <= 1'b0;
                    rn_r <= 4'h0;
                end else begin
                    rv_r <= 1'b0;
                    if (tick) begin
                        if (!ren) begin
                            rhold_r <= 4'h0;
                            rph_r <= 1'b0;
                        end else begin
                            rhold_r <= (slow & (rhold_r != HOLD_M1)) ? rhold_r + 4'h1 : 4'h0;
                            if (rhold_r == 4'h0) begin
                                if (!p_rmii[g]) begin
                                    rv_r <= 1'b1;
                                    rn_r <= rd;
                                end else if (!rph_r) begin
                                    rlo_r <= rd[1:0];
                                    rph_r <= 1'b1;
                                end else begin
                                    rv_r <= 1'b1;
                                    rn_r <= {rd[1:0], rlo_r};
                                    rph_r <= 1'b0;
                                end
                            end
                        end
                    end
                end
            end

            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    crs_r <= 1'b0;
                    col_r <= 1'b0;
                    drv_r <= 1'b0;
                end else begin
                    crs_r <= pv_r | ren;
                    col_r <= pv_r & ren;
                    drv_r <= mii_phy;
                end
            end

            assign lnk.p_txd[g] = pd_r;
            assign lnk.p_txen[g] = pv_r;
            assign lnk.p_rxc[g] = div_clk_r;
            assign lnk.p_txc[g] = div_clk_r;
            assign lnk.p_rxc_oe_n[g] = ~drv_r;
            assign lnk.p_txc_oe_n[g] = ~drv_r;
            assign lnk.p_crs[g] = crs_r;
            assign lnk.p_col[g] = col_r;
            assign lnk.p_cc_oe_n[g] = ~drv_r;
            assign tx_ready[g] = rdy_r;
            assign rx_valid[g] = rv_r;
            assign rx_nib[g] = rn_r;
        end
    endgenerate
endmodule

// ===== verif/spmri_link_monitor.sv
// pin-level assertions on the link between the ports and their partner
module spmri_link_monitor
    import spmri_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // device pins
    input wire logic [1:0] d_rxc,
    input wire logic [1:0] d_rxc_oe_n,
    input wire logic [1:0] d_txc,
    input wire logic [1:0] d_txc_oe_n,
    input wire logic [1:0] d_rxdv,
    input wire logic [1:0] d_crs,
    input wire logic [1:0] d_col,
    input wire logic [1:0] d_cc_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_RST_QUIET: assert property ($fell(sys_rst) |-> &{d_rxc_oe_n, d_txc_oe_n, d_cc_oe_n})
        else $error("pin driven at reset release");
    AST_RST_NO_DATA: assert property ($fell(sys_rst) |-> (d_rxdv == 2'h0)[*3])
        else $error("data valid before straps taken");
    for (genvar g = 0; g < 2; g++) begin : g_port
        AST_RXC_HIGH: assert property ($rose(d_rxc[g]) && !d_rxc_oe_n[g]
            |=> (d_rxc[g] || d_rxc_oe_n[g])[*3] ##1 (!d_rxc[g] || d_rxc_oe_n[g]))
            else $error("receive clock high phase wrong");
        AST_RXC_LOW: assert property ($fell(d_rxc[g]) && !d_rxc_oe_n[g]
            |=> (!d_rxc[g] || d_rxc_oe_n[g])[*3] ##1 (d_rxc[g] || d_rxc_oe_n[g]))
            else $error("receive clock low phase wrong");
        AST_TXC_HIGH: assert property ($rose(d_txc[g]) && !d_txc_oe_n[g]
            |=> (d_txc[g] || d_txc_oe_n[g])[*3] ##1 (!d_txc[g] || d_txc_oe_n[g]))
            else $error("transmit clock high phase wrong");
        AST_TXC_LOW: assert property ($fell(d_txc[g]) && !d_txc_oe_n[g]
            |=> (!d_txc[g] || d_txc_oe_n[g])[*3] ##1 (d_txc[g] || d_txc_oe_n[g]))
            else $error("transmit clock low phase wrong");
        AST_COL_CRS: assert property (!d_cc_oe_n[g] && d_col[g] |-> d_crs[g])
            else $error("collision without carrier");
        AST_CC_CLK: assert property (!d_cc_oe_n[g] |-> !d_rxc_oe_n[g] && !d_txc_oe_n[g])
            else $error("phy role without clock outputs");
    end
endmodule

// ===== verif/tb.sv
// self-checking bench: both ports against the link partner
module tb
    import spmri_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, sys_rst = 1'b1, refc = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
    logic s3 = 1'b1, s4 = 1'b1, sclk = 1'b1, role4 = 1'b0;
    logic [1:0] reg_addr = 2'h0, p_rmii = 2'h0, p_spd = 2'h0, p_phy = 2'h0, rm, sp, py;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, v, c, es;
    logic [3:0] tv = 4'h0, tr, rv, st, eo;
    logic [3:0][3:0] tn = 16'h0000, rn;
    logic [3:0] q[4][$];
    logic [29:0] ph[4] = '{{8'h00, 4'he, 6'h00, 8'h80, 4'h0}, {8'h09, 4'h2, 6'h34, 8'h83, 4'hb},
                           {8'h40, 4'hf, 6'h03, 8'h98, 4'hf}, {8'h06, 4'h0, 6'h38, 8'h87, 4'hf}};
    int num_errors = 0, comparisons = 0, cyc = 0, seed = 32'h2c7a82a1;
    spmri_link_if lnk();
    assign lnk.ext_ref = {2{refc}};
    spmri_switch_port u_spmri_switch_port (.clk(clk), .sys_rst(sys_rst), .lnk(lnk.dev),
        .port3_interface_type_strap(s3), .port4_interface_type_strap(s4), .clock_source_strap(sclk),
        .port4_role_cfg(role4), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .tx_valid(tv[1:0]), .tx_nib(tn[1:0]), .tx_ready(tr[1:0]),
        .rx_valid(rv[3:2]), .rx_nib(rn[3:2]));
    spmri_link_partner u_spmri_link_partner (.clk(clk), .sys_rst(sys_rst), .lnk(lnk.par), .p_rmii(p_rmii),
        .p_speed10(p_spd), .p_is_phy(p_phy), .tx_valid(tv[3:2]), .tx_nib(tn[3:2]), .tx_ready(tr[3:2]),
        .rx_valid(rv[1:0]), .rx_nib(rn[1:0]));
    spmri_link_monitor u_spmri_link_monitor (.clk(clk), .sys_rst(sys_rst), .d_rxc(lnk.d_rxc),
        .d_rxc_oe_n(lnk.d_rxc_oe_n), .d_txc(lnk.d_txc), .d_txc_oe_n(lnk.d_txc_oe_n), .d_rxdv(lnk.d_rxdv),
        .d_crs(lnk.d_crs), .d_col(lnk.d_col), .d_cc_oe_n(lnk.d_cc_oe_n));
    initial forever #12.5 clk = ~clk;
    initial forever #100 refc = ~refc;
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    // one stream: hold each nibble until the sender sees ready
    task automatic send(input int k);
        logic [3:0] n;
        int w;
        for (int i = 0; i < 6; i++) begin
            n = 4'($random(seed));
            q[k].push_back(n);
            tv[k] <= 1'b1;
            tn[k] <= n;
            w = 0;
            do begin
                @(posedge clk);
                w++;
            end while (tr[k] !== 1'b1 && w < 2000);
        end
        tv[k] <= 1'b0;
    endtask
    always @(posedge clk) begin : rx_mon
        logic [3:0] e;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            wrap_up();
        end
        for (int k = 0; k < 4; k++) begin
            if (rv[k] === 1'b1) begin
                e = (q[k].size() > 0) ? q[k].pop_front() : 4'hx;
                chk("rx nibble", {4'h0, e}, {4'h0, rn[k]});
            end
        end
    end
    initial begin
        for (int t = 0; t < 4; t++) begin
            {c, st, rm, sp, py, es, eo} = ph[t];
            @(posedge clk);
            sys_rst <= 1'b1;
            {s3, s4, sclk, role4} <= st;
            p_rmii <= rm;
            p_spd <= sp;
            p_phy <= py;
            repeat (5) @(posedge clk);
            sys_rst <= 1'b0;
            v = 8'h00;
            for (int i = 0; i < 20 && v[7] !== 1'b1; i++)
                rd(REG_STAT, v);
            wr(REG_CTRL, c);
            rd(REG_CTRL, v);
            chk("control", c, v);
            rd(REG_STAT, v);
            chk("status", es, v);
            rd(2'h2, v);
            chk("unmapped", 8'h00, v);
            chk("oe", {4'h0, eo}, {4'h0, lnk.d_rxc_oe_n, lnk.d_txc_oe_n});
            fork
                send(0);
                send(1);
                send(2);
                send(3);
            join
            for (int i = 0; i < 3000 && q[0].size() + q[1].size() + q[2].size() + q[3].size() > 0; i++)
                @(posedge clk);
            chk("left", 8'h00, 8'(q[0].size() + q[1].size() + q[2].size() + q[3].size()));
            // let the last collision clear the synchroniser before the clear
            repeat (16) @(posedge clk);
            rd(REG_STAT, v);
            // mii runs collide on both ports, rmii never flags
            chk("collision", (t % 2 == 0) ? (es | 8'h60) : es, v);
            wr(REG_STAT, 8'h60);
            rd(REG_STAT, v);
            chk("collision clear", es, v);
            $display("test %0d done", t);
        end
        wrap_up();
    end
endmodule
